// *** design/ds3_ds2_error_injector.sv ***
// transmit-side error injector and tributary spare bit control, ahb-lite slave
// assumes a frame builder on hclk presenting tagged bits, and a line driver draining out
//
// Chosen here: register access over AHB-Lite and the register offsets.
`include "ds3_err_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ds3_ds2_error_injector #(
  parameter int unsigned BURST_BITS = `BURST_BITS_DEF,
  parameter int unsigned COUNT_W = `COUNT_W_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // tagged bit stream from the frame builder
  input wire logic in_valid,
  input wire logic in_bit,
  input wire logic in_frame_start,
  input wire ds3_err_pkg::slot_kind_type in_kind,
  input wire logic [1:0] in_cidx,
  output logic in_ready,
  // ami line output
  input wire logic out_ready,
  output logic out_valid,
  output logic out_pos,
  output logic out_neg
);
  import ds3_err_pkg::*;

  logic wr_q;
  logic [`REG_AW-1:0] wa_q;
  err_type_type etype_q;
  rate_type rate_q;
  rate_type rate_eff;
  logic en_q;
  logic spare_q;
  logic [COUNT_W-1:0] count_q;
  logic acc_q;
  logic par_q;
  logic last_pol_q;
  logic sel_ok;
  logic cmd_insert;
  logic cmd_toggle;
  logic [31:0] rd_word;
  logic elig;
  logic accept;
  logic step;
  logic inject;
  logic pending;
  logic bursting;
  logic pre_bit;
  logic post_bit;
  logic bpv_flag;
  logic los_flag;
  logic buf_valid;
  logic buf_ready;
  logic [`BUF_W-1:0] buf_data;
  logic pop;

  // c-bit position selected by a type, c1 is index zero
  function automatic logic [1:0] c_pos(input err_type_type t);
    case (t)
      E_HC2, E_TC2: c_pos = 2'h1;
      E_HC3, E_TC3: c_pos = 2'h2;
      default: c_pos = 2'h0;
    endcase
  endfunction

  // address phase qualification, zero wait states
  assign sel_ok = hsel && hready && htrans[1];
  assign cmd_insert = wr_q && (wa_q == `ADDR_CMD) && hwdata[`CMD_INSERT_BIT];
  assign cmd_toggle = wr_q && (wa_q == `ADDR_CMD) && hwdata[`CMD_TOGGLE_BIT];

  // address phase capture and constant okay answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_q <= sel_ok && hwrite;
      wa_q <= haddr[`REG_AW-1:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control register write in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      etype_q <= E_NONE;
      rate_q <= RATE_OFF;
      en_q <= `RST_EN;
    end else if (wr_q && wa_q == `ADDR_CTRL) begin
      etype_q <= err_type_type'(hwdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB]);
      rate_q <= rate_type'(hwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
      en_q <= hwdata[`CTRL_EN_BIT];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[`REG_AW-1:0])
      `ADDR_CTRL: begin
        rd_word[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] = etype_q;
        rd_word[`CTRL_RATE_MSB:`CTRL_RATE_LSB] = rate_q;
        rd_word[`CTRL_EN_BIT] = en_q;
      end
      `ADDR_STATUS: begin
        rd_word[`STAT_SPARE_BIT] = spare_q;
        rd_word[`STAT_PEND_BIT] = pending;
        rd_word[`STAT_BURST_BIT] = bursting;
        rd_word[`STAT_EN_BIT] = en_q;
      end
      `ADDR_COUNT: rd_word[COUNT_W-1:0] = count_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (sel_ok && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // tributary spare bit level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spare_q <= `RST_SPARE;
    end else if (cmd_toggle) begin
      spare_q <= ~spare_q;
    end
  end

  // rate limits per type: loss takes continuous, burst, off; others never continuous
  always_comb begin
    if (etype_q == E_SIGNAL_LOSS) begin
      rate_eff = (rate_q == RATE_CONT || rate_q == RATE_BURST) ? rate_q : RATE_OFF;
    end else begin
      rate_eff = (rate_q == RATE_CONT) ? RATE_OFF : rate_q;
    end
  end

  // which bit slots the selected type may corrupt
  always_comb begin
    case (etype_q)
      E_PAYLOAD_ONLY, E_PAYLOAD_PARITY: elig = (in_kind == K_PAYLOAD);
      E_BPV: elig = (in_kind == K_PAYLOAD) && in_bit;
      E_FRAMING: elig = (in_kind == K_FBIT);
      E_HC1, E_HC2, E_HC3: elig = (in_kind == K_CBIT_HI) && (in_cidx == c_pos(etype_q));
      E_HC_ALL: elig = (in_kind == K_CBIT_HI);
      E_TC1, E_TC2, E_TC3: elig = (in_kind == K_CBIT_TRIB) && (in_cidx == c_pos(etype_q));
      E_TC_ALL: elig = (in_kind == K_CBIT_TRIB);
      E_SIGNAL_LOSS: elig = 1'b1;
      default: elig = 1'b0;
    endcase
  end

  assign accept = in_valid && in_ready;
  assign step = accept && elig && en_q;

  rate_gen #(
    .BURST_BITS(BURST_BITS)
  ) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .step(step),
    .arm(cmd_insert),
    .rate(rate_eff),
    .inject(inject),
    .pending(pending),
    .bursting(bursting)
  );

  // corruption ahead of and after the parity tap
  assign pre_bit = in_bit ^ (inject && etype_q == E_PAYLOAD_ONLY);
  assign bpv_flag = inject && (etype_q == E_BPV);
  assign los_flag = inject && (etype_q == E_SIGNAL_LOSS);
  always_comb begin
    case (in_kind)
      K_PBIT: post_bit = par_q;
      K_XBIT_TRIB: post_bit = spare_q;
      default: post_bit = pre_bit ^ (inject && etype_q != E_PAYLOAD_ONLY &&
                                     etype_q != E_BPV && etype_q != E_SIGNAL_LOSS);
    endcase
  end

  // running parity of the payload, latched for the next frame's parity slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 1'b0;
      par_q <= 1'b0;
    end else if (accept && in_frame_start) begin
      par_q <= acc_q;
      acc_q <= 1'b0;
    end else if (accept && in_kind == K_PAYLOAD) begin
      acc_q <= acc_q ^ pre_bit;
    end
  end

  // injected error tally
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (inject) begin
      count_q <= count_q + COUNT_W'(1);
    end
  end

  two_entry_buffer #(
    .W(`BUF_W)
  ) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({los_flag, bpv_flag, post_bit}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  assign buf_ready = !out_valid || out_ready;
  assign pop = buf_valid && buf_ready;

  // ami encoder: alternate marks, repeat polarity on violation, silence on loss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_pos <= 1'b0;
      out_neg <= 1'b0;
      last_pol_q <= 1'b0;
    end else if (pop) begin
      out_valid <= 1'b1;
      if (buf_data[2] || !buf_data[0]) begin
        out_pos <= 1'b0;
        out_neg <= 1'b0;
      end else if (buf_data[1]) begin
        out_pos <= last_pol_q;
        out_neg <= ~last_pol_q;
      end else begin
        out_pos <= ~last_pol_q;
        out_neg <= last_pol_q;
        last_pol_q <= ~last_pol_q;
      end
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  a_spare_flip: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_toggle |=> spare_q != $past(spare_q))
    else $error("spare bit did not flip on toggle");
  a_rate_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    inject |-> en_q && accept)
    else $error("error injected without ds3 enable");
  a_parity_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !in_frame_start && in_kind == K_PAYLOAD && etype_q == E_PAYLOAD_ONLY)
    |=> acc_q == ($past(acc_q) ^ $past(in_bit) ^ $past(inject)))
    else $error("parity does not follow corrupted payload");
  a_parity_clean: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !in_frame_start && in_kind == K_PAYLOAD && etype_q == E_PAYLOAD_PARITY)
    |=> acc_q == ($past(acc_q) ^ $past(in_bit)))
    else $error("parity saw the corrupted payload");
  a_frame_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && etype_q == E_FRAMING) |-> in_kind == K_FBIT && post_bit != in_bit)
    else $error("framing error outside a framing bit");
  a_hi_cpos: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && etype_q inside {E_HC1, E_HC2, E_HC3})
    |-> in_kind == K_CBIT_HI && in_cidx == c_pos(etype_q))
    else $error("high-order c-bit error in wrong position");
  a_hi_call: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && etype_q == E_HC_ALL) |-> in_kind == K_CBIT_HI)
    else $error("all c-bit error outside a c-bit");
  a_trib_cpos: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && etype_q inside {E_TC1, E_TC2, E_TC3, E_TC_ALL})
    |-> in_kind == K_CBIT_TRIB && (etype_q == E_TC_ALL || in_cidx == c_pos(etype_q)))
    else $error("tributary c-bit error in wrong slot");
  a_los_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (pop && buf_data[2]) |=> out_valid && !out_pos && !out_neg)
    else $error("line not silent during loss");
  a_bpv_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
    (pop && buf_data[1] && buf_data[0] && !buf_data[2])
    |=> out_pos == $past(last_pol_q) && out_neg != out_pos)
    else $error("violation mark polarity wrong");
  c_ratio_hit: cover property (@(posedge hclk) disable iff (!hresetn)
    inject && rate_eff == RATE_E2);
  c_los_on: cover property (@(posedge hclk) disable iff (!hresetn)
    pop && buf_data[2]);
  c_stall_full: cover property (@(posedge hclk) disable iff (!hresetn)
    in_valid && !in_ready);
endmodule
`default_nettype wire

// *** design/ds3_err_defs.svh ***
// register map, field positions, reset values and counts of the error injector
// assumes inclusion by bare name from every design file that needs it
`ifndef DS3_ERR_DEFS_SVH
`define DS3_ERR_DEFS_SVH

// register byte offsets within the decoded window
`define REG_AW 12
`define ADDR_CTRL 12'h000
`define ADDR_CMD 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_COUNT 12'h00c

// control register fields
`define CTRL_TYPE_LSB 0
`define CTRL_TYPE_MSB 3
`define CTRL_RATE_LSB 4
`define CTRL_RATE_MSB 7
`define CTRL_EN_BIT 8

// command register fields, write one to act
`define CMD_INSERT_BIT 0
`define CMD_TOGGLE_BIT 1

// status register fields
`define STAT_SPARE_BIT 0
`define STAT_PEND_BIT 1
`define STAT_BURST_BIT 2
`define STAT_EN_BIT 3

// reset values
`define RST_SPARE 1'b0
`define RST_EN 1'b0

// sizes and counts
`define COUNT_W_DEF 16
`define BURST_BITS_DEF 1000
`define RATIO_CW 30
`define BUF_W 3

`endif

// *** design/ds3_err_pkg.sv ***
// types shared by the error injector modules
// assumes nothing of its surroundings
package ds3_err_pkg;

  // selected error type
  typedef enum logic [3:0] {
    E_NONE = 4'h0,
    E_PAYLOAD_ONLY = 4'h1,
    E_PAYLOAD_PARITY = 4'h2,
    E_BPV = 4'h3,
    E_FRAMING = 4'h4,
    E_HC1 = 4'h5,
    E_HC2 = 4'h6,
    E_HC3 = 4'h7,
    E_HC_ALL = 4'h8,
    E_SIGNAL_LOSS = 4'h9,
    E_TC1 = 4'ha,
    E_TC2 = 4'hb,
    E_TC3 = 4'hc,
    E_TC_ALL = 4'hd
  } err_type_type;

  // selected injection rate
  typedef enum logic [3:0] {
    RATE_OFF = 4'h0,
    RATE_SINGLE = 4'h1,
    RATE_BURST = 4'h2,
    RATE_CONT = 4'h3,
    RATE_E2 = 4'h4,
    RATE_E3 = 4'h5,
    RATE_E4 = 4'h6,
    RATE_E5 = 4'h7,
    RATE_E6 = 4'h8,
    RATE_E7 = 4'h9,
    RATE_E8 = 4'ha,
    RATE_E9 = 4'hb
  } rate_type;

  // kind of the bit slot presented by the frame builder
  typedef enum logic [2:0] {
    K_PAYLOAD = 3'h0,
    K_FBIT = 3'h1,
    K_MBIT = 3'h2,
    K_PBIT = 3'h3,
    K_CBIT_HI = 3'h4,
    K_CBIT_TRIB = 3'h5,
    K_XBIT_TRIB = 3'h6,
    K_OTHER = 3'h7
  } slot_kind_type;

  // burst sequencer states
  typedef enum logic [1:0] {
    BG_IDLE = 2'b01,
    BG_RUN = 2'b10
  } burst_state_type;

endpackage

// *** design/rate_gen.sv ***
// decides, bit by eligible bit, whether an error goes in at the selected rate
// assumes step is high for exactly the eligible bits the caller accepts
`include "ds3_err_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rate_gen #(
  parameter int unsigned BURST_BITS = `BURST_BITS_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic step,
  input wire logic arm,
  input wire ds3_err_pkg::rate_type rate,
  // results
  output logic inject,
  output logic pending,
  output logic bursting
);
  import ds3_err_pkg::*;

  logic [`RATIO_CW-1:0] cnt_q;
  logic [15:0] bcnt_q;
  burst_state_type bst_q;
  logic is_ratio;
  logic hit;

  // ten to the n, less one, for ratio rates
  function automatic logic [`RATIO_CW-1:0] ratio_term(input rate_type r);
    logic [`RATIO_CW-1:0] t;
    int n;
    t = `RATIO_CW'(1);
    n = int'(r) - int'(RATE_E2) + 2;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        t = `RATIO_CW'(t * `RATIO_CW'(10));
      end
    end
    return t - `RATIO_CW'(1);
  endfunction

  // one error per ten-to-the-n eligible bits
  assign is_ratio = (rate >= RATE_E2) && (rate <= RATE_E9);
  assign hit = is_ratio && (cnt_q == ratio_term(rate));
  assign inject = step && (hit || pending || bst_q == BG_RUN || rate == RATE_CONT);
  assign bursting = (bst_q == BG_RUN);

  // ratio counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!is_ratio) begin
      cnt_q <= '0;
    end else if (step) begin
      cnt_q <= hit ? '0 : cnt_q + `RATIO_CW'(1);
    end
  end

  // single insert: arm sets, consumption clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= 1'b0;
    end else if (arm && rate == RATE_SINGLE) begin
      pending <= 1'b1;
    end else if (step || rate != RATE_SINGLE) begin
      pending <= 1'b0;
    end
  end

  // burst sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_q <= BG_IDLE;
      bcnt_q <= 16'h0000;
    end else begin
      case (bst_q)
        BG_IDLE: begin
          if (arm && rate == RATE_BURST) begin
            bst_q <= BG_RUN;
            bcnt_q <= 16'h0000;
          end
        end
        BG_RUN: begin
          if (rate != RATE_BURST) begin
            bst_q <= BG_IDLE;
          end else if (step) begin
            bcnt_q <= bcnt_q + 16'h0001;
            if (bcnt_q == 16'(BURST_BITS - 1)) begin
              bst_q <= BG_IDLE;
            end
          end
        end
        default: begin
          bst_q <= BG_IDLE;
        end
      endcase
    end
  end

  // ratio error lands exactly on the terminal count
  a_ratio_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && is_ratio && !pending && bst_q != BG_RUN) |-> cnt_q == ratio_term(rate))
    else $error("ratio error off its terminal count");
  // off held for three cycles never injects
  a_off_silent: assert property (@(posedge hclk) disable iff (!hresetn)
    (rate == RATE_OFF && $past(rate) == RATE_OFF && $past(rate, 2) == RATE_OFF) |-> !inject)
    else $error("error injected while rate off");
  // single insert gives one error then stops
  a_single_once: assert property (@(posedge hclk) disable iff (!hresetn)
    (inject && pending && !arm && rate == RATE_SINGLE) |=> !pending)
    else $error("single insert not consumed");
  c_burst_done: cover property (@(posedge hclk) disable iff (!hresetn)
    bst_q == BG_RUN ##1 bst_q == BG_IDLE);
endmodule
`default_nettype wire

// *** design/two_entry_buffer.sv ***
// two-entry valid/ready buffer with a registered ready on the fill side
// assumes both sides on hclk; drain side may stall at will
`include "ds3_err_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int unsigned W = `BUF_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  logic [1:0] cnt_d;

  // handshakes and next fill level
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  // storage write
  always_ff @(posedge hclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers, level and registered ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != 2'h2);
    end
  end
endmodule
`default_nettype wire

// *** dv/ds3_ds2_error_injector_tb.sv ***
// self-checking bench: ahb-lite master, tagged bit source, reference injector
// assumes line_rx_model as the line receiver and hready looped from hreadyout
`timescale 1ns/1ps
`default_nettype none
module ds3_ds2_error_injector_tb;
  import ds3_err_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold = 1'b0;
  logic in_valid = 1'b0, in_bit = 1'b0, in_frame_start = 1'b0, saw_full = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00, in_cidx = 2'b00, exp_q[$];
  logic [2:0] hsize = 3'b010;
  slot_kind_type in_kind = K_OTHER;
  logic hready, hreadyout, hresp, in_ready, out_ready, out_valid, out_pos, out_neg;
  int miscompares = 0, cmp_count = 0, cyc = 0, rcnt = 0, burst_left = 0, errs = 0;
  // reference model state
  err_type_type typ = E_NONE;
  rate_type rate = RATE_OFF;
  logic en = 1'b0, spare = 1'b0, pend = 1'b0, pol = 1'b0, par = 1'b0, plat = 1'b0;
  err_type_type tl[13] = '{E_PAYLOAD_ONLY, E_PAYLOAD_PARITY, E_BPV, E_FRAMING, E_HC1,
    E_HC2, E_HC3, E_HC_ALL, E_TC1, E_TC2, E_TC3, E_TC_ALL, E_FRAMING};
  assign hready = hreadyout;

  ds3_ds2_error_injector #(.BURST_BITS(4), .COUNT_W(16)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_bit(in_bit),
    .in_frame_start(in_frame_start), .in_kind(in_kind), .in_cidx(in_cidx),
    .in_ready(in_ready), .out_ready(out_ready), .out_valid(out_valid),
    .out_pos(out_pos), .out_neg(out_neg));
  line_rx_model rx (.hclk(hclk), .hresetn(hresetn), .hold(hold), .out_valid(out_valid),
    .out_pos(out_pos), .out_neg(out_neg), .out_ready(out_ready));

  // 10 mhz clock
  initial begin
    forever #50 hclk = ~hclk;
  end
  // periodic long line stalls so the buffer fills
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    hold <= (cyc % 64) < 12;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  // wait for the rising edge at which hready is sampled high
  task automatic wait_rdy();
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  // one single transfer; read data taken at the closing edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    check(hresp, 1'b0);
    hsel <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic cmd(input logic [1:0] d);
    ahb(1'b1, 32'h4, {30'h0, d});
    if (d[0] && rate == RATE_SINGLE) pend = 1'b1;
    if (d[0] && rate == RATE_BURST) burst_left = 4;
    if (d[1]) spare = !spare;
  endtask
  task automatic set_ctrl(input err_type_type t, input rate_type r, input logic e);
    typ = t;
    rate = r;
    en = e;
    if (r < RATE_E2) rcnt = 0;
    ahb(1'b1, 32'h0, {23'h0, e, r, t});
    rchk(32'h0, {23'h0, e, r, t});
  endtask

  // which slots the selected type may corrupt
  function automatic logic elig(slot_kind_type k, logic [1:0] c, logic b);
    case (typ)
      E_PAYLOAD_ONLY, E_PAYLOAD_PARITY: return k == K_PAYLOAD;
      E_BPV: return k == K_PAYLOAD && b;
      E_FRAMING: return k == K_FBIT;
      E_HC1, E_HC2, E_HC3: return k == K_CBIT_HI && c + 4'h5 == typ;
      E_HC_ALL: return k == K_CBIT_HI;
      E_TC1, E_TC2, E_TC3: return k == K_CBIT_TRIB && c + 4'ha == typ;
      E_TC_ALL: return k == K_CBIT_TRIB;
      E_SIGNAL_LOSS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // injection decision for one eligible bit
  function automatic logic inj_now();
    logic r;
    r = 1'b0;
    if (typ == E_SIGNAL_LOSS && rate == RATE_CONT) r = 1'b1;
    else if (burst_left > 0) begin
      r = 1'b1;
      burst_left--;
    end else if (typ != E_SIGNAL_LOSS && pend) begin
      r = 1'b1;
      pend = 1'b0;
    end else if (typ != E_SIGNAL_LOSS && rate >= RATE_E2) begin
      rcnt++;
      r = rcnt == 10 ** (rate - RATE_E2 + 2);
      if (r) rcnt = 0;
    end
    errs += r;
    return r;
  endfunction
  // offer one bit and queue the symbol the line should carry
  task automatic put(input slot_kind_type k, input logic [1:0] c, input logic fs,
    input logic b);
    logic i, m, v;
    i = en && elig(k, c, b) && inj_now();
    v = i && typ == E_BPV;
    m = (k == K_XBIT_TRIB) ? spare : (k == K_PBIT) ? plat : b ^ (i && !v);
    if (i && typ == E_SIGNAL_LOSS) m = 1'b0;
    if (k == K_PAYLOAD) par ^= (typ == E_PAYLOAD_PARITY) ? b : m;
    if (fs) begin
      plat = par;
      par = 1'b0;
    end
    if (m && !v) pol = !pol;
    exp_q.push_back(m ? (pol ? 2'b10 : 2'b01) : 2'b00);
    @(posedge hclk);
    in_valid <= 1'b1;
    in_kind <= k;
    in_cidx <= c;
    in_frame_start <= fs;
    in_bit <= b;
    @(negedge hclk);
    while (in_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge hclk);
    end
  endtask
  task automatic drain();
    int n;
    @(posedge hclk);
    in_valid <= 1'b0;
    n = 0;
    while (rx.q.size() < exp_q.size() && n < 400) begin
      @(posedge hclk);
      n++;
    end
    check(rx.q.size(), exp_q.size());
    foreach (exp_q[j]) if (j < rx.q.size()) check(rx.q[j], exp_q[j]);
    rx.q.delete();
    exp_q.delete();
  endtask
  task automatic stream(input int n);
    slot_kind_type tgt;
    slot_kind_type kt[6] = '{K_PAYLOAD, K_FBIT, K_MBIT, K_CBIT_HI, K_CBIT_TRIB, K_XBIT_TRIB};
    tgt = (typ >= E_TC1) ? K_CBIT_TRIB : (typ >= E_HC1) ? K_CBIT_HI :
      (typ == E_FRAMING) ? K_FBIT : K_PAYLOAD;
    for (int j = 0; j < n; j++) begin
      put($urandom_range(1) ? tgt : kt[$urandom_range(5)], 2'($urandom_range(2)), 1'b0,
        1'($urandom));
    end
    drain();
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #8000000;
    miscompares++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(32'ha0a5142e));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h8, 32'h0);
    rchk(32'h0, 32'h0);
    rchk(32'hc, 32'h0);
    rchk(32'h10, 32'h0);
    cmd(2'b10);
    rchk(32'h8, 32'h1);
    rchk(32'h4, 32'h0);
    cmd(2'b10);
    rchk(32'h8, 32'h0);
    for (int r = 0; r < 12; r++) set_ctrl(E_PAYLOAD_ONLY, rate_type'(r), 1'b1);
    cmd(2'b10);
    set_ctrl(E_PAYLOAD_ONLY, RATE_SINGLE, 1'b1);
    cmd(2'b01);
    rchk(32'h8, 32'hb);
    stream(30);
    rchk(32'h8, 32'h9);
    // parity before and after corruption
    for (int md = 1; md < 3; md++) begin
      set_ctrl(err_type_type'(md), RATE_SINGLE, 1'b1);
      cmd(2'b01);
      put(K_OTHER, 2'b00, 1'b1, 1'b0);
      repeat (6) put(K_PAYLOAD, 2'b00, 1'b0, 1'($urandom));
      put(K_OTHER, 2'b00, 1'b1, 1'b0);
      put(K_PBIT, 2'b00, 1'b0, 1'b0);
      drain();
    end
    // each type but loss at 1e-2, the last one with injection disabled
    for (int i = 0; i < 13; i++) begin
      set_ctrl(tl[i], RATE_OFF, 1'b1);
      set_ctrl(tl[i], RATE_E2, i < 12);
      stream(1100);
      rchk(32'hc, 32'(errs[15:0]));
      if (i == 6) cmd(2'b10);
    end
    set_ctrl(E_PAYLOAD_ONLY, RATE_OFF, 1'b1);
    set_ctrl(E_PAYLOAD_ONLY, RATE_E3, 1'b1);
    stream(2000);
    rchk(32'hc, 32'(errs[15:0]));
    // burst on a non-loss type
    set_ctrl(E_HC_ALL, RATE_BURST, 1'b1);
    cmd(2'b01);
    rchk(32'h8, 32'hc);
    stream(40);
    rchk(32'hc, 32'(errs[15:0]));
    // loss of signal: burst, continuous, then single which acts as off
    set_ctrl(E_SIGNAL_LOSS, RATE_BURST, 1'b1);
    cmd(2'b01);
    rchk(32'h8, 32'hc);
    stream(10);
    set_ctrl(E_SIGNAL_LOSS, RATE_CONT, 1'b1);
    stream(8);
    set_ctrl(E_SIGNAL_LOSS, RATE_SINGLE, 1'b1);
    cmd(2'b01);
    stream(8);
    check(saw_full, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** dv/line_rx_model.sv ***
// line receiver model: takes ami symbols, stalls at random and on demand
// assumes the injector's out_* valid/ready handshake on hclk
`timescale 1ns/1ps
`default_nettype none
module line_rx_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // long stall request from the bench
  input wire logic hold,
  // ami line
  input wire logic out_valid,
  input wire logic out_pos,
  input wire logic out_neg,
  output logic out_ready
);
  logic [1:0] q[$];
  // store each taken symbol, then pick the next ready level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ready <= 1'b0;
      q.delete();
    end else begin
      if (out_valid && out_ready) begin
        q.push_back({out_pos, out_neg});
      end
      out_ready <= !hold && ($urandom_range(3) != 0);
    end
  end
endmodule
`default_nettype wire
